/* File: design/perm_pkg.sv */
// package of constants for the port error event and rate monitor
package perm_pkg;
  // apb register byte offsets
  localparam logic [7:0] REG_ERR_DETECT = 8'h00;
  localparam logic [7:0] REG_ERR_NOTIFY_EN = 8'h04;
  localparam logic [7:0] REG_ERR_PW_EN = 8'h08;
  localparam logic [7:0] REG_RATE_ENABLE = 8'h0C;
  localparam logic [7:0] REG_RATE_CTRL = 8'h10;
  localparam logic [7:0] REG_RATE_THRESH = 8'h14;
  localparam logic [7:0] REG_PORT_STATUS = 8'h18;
  localparam logic [7:0] REG_PORT_CTRL = 8'h1C;
  localparam logic [7:0] REG_LATENCY = 8'h20;
  localparam logic [7:0] REG_RATE_COUNTER = 8'h24;
  // error flag bit positions
  localparam int NUM_ERR = 8;
  localparam int BAD_SEQ_BIT = 0;
  localparam int OVERSIZE_BIT = 1;
  localparam int BAD_RESP_BIT = 2;
  localparam int PROTO_BIT = 3;
  localparam int DELIN_BIT = 4;
  localparam int UNEXP_ACC_BIT = 5;
  localparam int ACK_TO_BIT = 6;
  localparam int CS_CRC_BIT = 7;
  // port status bit positions
  localparam int ST_DEGRADED = 0;
  localparam int ST_FAILED = 1;
  localparam int ST_OUT_DROP = 2;
  localparam int ST_OUT_FAIL = 3;
  localparam int ST_MC_TIMEOUT = 4;
  localparam int ST_LAT_EXPIRED = 5;
  localparam int ST_FABRIC_IRQ = 6;
  localparam int NUM_ST = 7;
  // port control bit positions
  localparam int CTL_DROP_EN = 0;
  localparam int CTL_FWD_TO_EN = 1;
  localparam int CTL_DEG_IRQ = 2;
  localparam int CTL_FAIL_IRQ = 3;
  localparam int CTL_DEG_PW = 4;
  localparam int CTL_FAIL_PW = 5;
  // sizes and reset values
  localparam int MAX_PKT_BYTES = 276;
  localparam int CNT_W = 8;
  localparam int BIAS_W = 16;
  localparam int LAT_W = 24;
  localparam logic [LAT_W-1:0] LAT_MAX = 24'hFFFFFF;
  localparam real LAT_STEP_NS = 6.4;
  localparam real CLK_PERIOD_NS = 50.0;
  localparam logic [BIAS_W-1:0] BIAS_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] DEG_RESET = 8'hFF;
  localparam logic [CNT_W-1:0] FAIL_RESET = 8'hFF;
  localparam logic [CNT_W-1:0] HEADROOM_RESET = 8'h00;
  localparam logic [NUM_ERR-1:0] ENABLE_RESET = 8'h00;
endpackage : perm_pkg

/* File: design/perm_monitor.sv */
// port error event detection, notification and error-rate monitor
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
// How it works
// - each enabled event drives the low-active interrupt, a port-write pulse, or both
// - all events are handled in parallel with no priority between them
// - out-of-sequence packet ackID sets the bad packet sequence flag
// - packets longer than 276 bytes set the oversize packet flag
// - link-response with an unused ackID sets the bad response id flag
// - unexpected well-formed control symbol sets the protocol violation flag
// - misaligned delimiter or undefined code group sets the delineation fault flag
// - unexpected packet-accepted symbol sets the unexpected accept flag
// - missing acknowledgement within allowed time sets the ack timeout flag
// - control symbol crc failure sets its crc error flag
// - one rate counter counts every listed transmission error
// - bias ticks decrement the rate counter and congestion counter, floor zero
// - only error types enabled in the rate enable register are counted
// - counter stops at threshold plus recovery headroom
// - peak holds the highest count; only software lowers it
// - degraded and failed thresholds are programmed separately
// - degraded event raised once per rising crossing of its threshold
// - failed event raised once per rising crossing of its threshold
// - drop on fail discards transmitting packet, sets dropped and failed flags
// - forward timeout discards head packet, sets dropped and fabric interrupt bit
// - multicast copy timeout discards the copy and sets multicast timeout flag
// - latency expiry sets latency expired bit and purges broadcast buffer
// - latency timer starts when a packet is fully held, period in sys_clk cycles
module perm_monitor
  import perm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // receive-side error strobes from the link logic
  input wire logic rxAckIdOutOfSeq,
  input wire logic rxPktEnd,
  input wire logic [8:0] rxPktBytes,
  input wire logic rxRespIdUnused,
  input wire logic rxUnexpectedSymbol,
  input wire logic rxDelineation,
  input wire logic rxUnexpectedAccept,
  input wire logic ackTimerExpired,
  input wire logic rxSymbolCrcBad,
  // packet flow conditions
  input wire logic txBusy,
  input wire logic forwardTimeout,
  input wire logic mcCopyBlocked,
  input wire logic bcastPktHeld,
  input wire logic bcastDraining,
  // outputs
  output logic intN,
  output logic portWriteReq,
  output logic txDrop,
  output logic ingressDrop,
  output logic mcCopyDrop,
  output logic bcastPurge,
  output logic [CNT_W-1:0] congestionCount
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [NUM_ERR-1:0] errFlags;
    logic [NUM_ERR-1:0] notifyEn;
    logic [NUM_ERR-1:0] pwEn;
    logic [NUM_ERR-1:0] rateEn;
    logic [BIAS_W-1:0] biasPeriod;
    logic [BIAS_W-1:0] biasCnt;
    logic [CNT_W-1:0] rateCnt;
    logic [CNT_W-1:0] peak;
    logic [CNT_W-1:0] headroom;
    logic [CNT_W-1:0] degThresh;
    logic [CNT_W-1:0] failThresh;
    logic [CNT_W-1:0] congCnt;
    logic [NUM_ST-1:0] status;
    logic [5:0] ctrl;
    logic [LAT_W-1:0] latPeriod;
    logic [LAT_W-1:0] latCnt;
    logic latRun;
    logic degArmed;
    logic failArmed;
    logic [31:0] rdata;
    logic ready;
    logic slvErr;
    logic intN;
    logic pwReq;
    logic txDrop;
    logic inDrop;
    logic mcDrop;
    logic purge;
  } perm_state_t;

  perm_state_t cur_ff;
  perm_state_t nxt_cur;

  // ==========================================================
  // helpers
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a <= REG_RATE_COUNTER) && (a[1:0] == 2'b00);
  endfunction : isMapped

  // apb access phase strobe
  logic apbAccess;
  logic wrEn;
  logic [NUM_ERR-1:0] errEvents;
  logic tick;
  logic incr;
  logic decr;
  logic [CNT_W:0] ceiling;
  logic latExpire;

  assign apbAccess = psel && penable && !cur_ff.ready;
  assign wrEn = apbAccess && pwrite && isMapped(paddr);

  // raw error events, all in parallel
  always_comb begin
    errEvents = '0;
    errEvents[BAD_SEQ_BIT] = rxAckIdOutOfSeq;
    errEvents[OVERSIZE_BIT] = rxPktEnd && (rxPktBytes > 9'(MAX_PKT_BYTES));
    errEvents[BAD_RESP_BIT] = rxRespIdUnused;
    errEvents[PROTO_BIT] = rxUnexpectedSymbol;
    errEvents[DELIN_BIT] = rxDelineation;
    errEvents[UNEXP_ACC_BIT] = rxUnexpectedAccept;
    errEvents[ACK_TO_BIT] = ackTimerExpired;
    errEvents[CS_CRC_BIT] = rxSymbolCrcBad;
  end

  // rate counter controls
  assign tick = (cur_ff.biasPeriod != '0) && (cur_ff.biasCnt == cur_ff.biasPeriod);
  assign ceiling = {1'b0, cur_ff.failThresh} + {1'b0, cur_ff.headroom};
  // the all-ones guard stops a wrap when threshold plus headroom exceeds the counter
  assign incr = |(errEvents & cur_ff.rateEn) && ({1'b0, cur_ff.rateCnt} < ceiling) &&
    (cur_ff.rateCnt != '1);
  assign decr = tick && (cur_ff.rateCnt != '0);
  assign latExpire = cur_ff.latRun && (cur_ff.latCnt >= cur_ff.latPeriod);

  // ==========================================================
  // next state
  always_comb begin
    nxt_cur = cur_ff;
    // one-cycle outputs default low
    nxt_cur.pwReq = 1'b0;
    nxt_cur.txDrop = 1'b0;
    nxt_cur.inDrop = 1'b0;
    nxt_cur.mcDrop = 1'b0;
    nxt_cur.purge = 1'b0;
    nxt_cur.ready = 1'b0;
    nxt_cur.slvErr = 1'b0;
    // bias timer; a count left above a newly written period restarts at zero
    // at once instead of wrapping through the whole 16-bit range first
    nxt_cur.biasCnt = (cur_ff.biasCnt >= cur_ff.biasPeriod) ? '0 :
      cur_ff.biasCnt + 1'b1;
    // software writes (hardware sets below win)
    if (wrEn) begin
      unique case (paddr)
        REG_ERR_DETECT: nxt_cur.errFlags = cur_ff.errFlags & ~pwdata[NUM_ERR-1:0];
        REG_ERR_NOTIFY_EN: nxt_cur.notifyEn = pwdata[NUM_ERR-1:0];
        REG_ERR_PW_EN: nxt_cur.pwEn = pwdata[NUM_ERR-1:0];
        REG_RATE_ENABLE: nxt_cur.rateEn = pwdata[NUM_ERR-1:0];
        REG_RATE_CTRL: begin
          nxt_cur.biasPeriod = pwdata[BIAS_W-1:0];
          nxt_cur.headroom = pwdata[BIAS_W+CNT_W-1:BIAS_W];
        end
        REG_RATE_THRESH: begin
          nxt_cur.degThresh = pwdata[CNT_W-1:0];
          nxt_cur.failThresh = pwdata[2*CNT_W-1:CNT_W];
        end
        REG_PORT_STATUS: nxt_cur.status = cur_ff.status & ~pwdata[NUM_ST-1:0];
        REG_PORT_CTRL: nxt_cur.ctrl = pwdata[5:0];
        REG_LATENCY: nxt_cur.latPeriod = pwdata[LAT_W-1:0];
        REG_RATE_COUNTER: begin
          nxt_cur.rateCnt = pwdata[CNT_W-1:0];
          nxt_cur.peak = pwdata[2*CNT_W-1:CNT_W];
        end
        default: ;
      endcase
    end
    // sticky error flags, set wins over clear
    nxt_cur.errFlags = nxt_cur.errFlags | errEvents;
    // rate counter: both at once leave it unchanged
    if (!(wrEn && paddr == REG_RATE_COUNTER)) begin
      if (incr && !decr) nxt_cur.rateCnt = cur_ff.rateCnt + 1'b1;
      else if (decr && !incr) nxt_cur.rateCnt = cur_ff.rateCnt - 1'b1;
      else nxt_cur.rateCnt = cur_ff.rateCnt;
    end
    if (tick && cur_ff.congCnt != '0) nxt_cur.congCnt = cur_ff.congCnt - 1'b1;
    // peak only rises by hardware
    if (nxt_cur.rateCnt > nxt_cur.peak) nxt_cur.peak = nxt_cur.rateCnt;
    // degraded threshold crossing
    if (cur_ff.rateCnt < cur_ff.degThresh) nxt_cur.degArmed = 1'b1;
    else if (cur_ff.degArmed) begin
      nxt_cur.degArmed = 1'b0;
      nxt_cur.status[ST_DEGRADED] = 1'b1;
      nxt_cur.pwReq = cur_ff.ctrl[CTL_DEG_PW];
    end
    // failed threshold crossing
    if (cur_ff.rateCnt < cur_ff.failThresh) nxt_cur.failArmed = 1'b1;
    else if (cur_ff.failArmed) begin
      nxt_cur.failArmed = 1'b0;
      nxt_cur.status[ST_FAILED] = 1'b1;
      nxt_cur.pwReq = nxt_cur.pwReq | cur_ff.ctrl[CTL_FAIL_PW];
      if (cur_ff.ctrl[CTL_DROP_EN] && txBusy) begin
        nxt_cur.txDrop = 1'b1;
        nxt_cur.status[ST_OUT_DROP] = 1'b1;
        nxt_cur.status[ST_OUT_FAIL] = 1'b1;
      end
    end
    // forward timeout of inbound head packet
    if (cur_ff.ctrl[CTL_FWD_TO_EN] && forwardTimeout) begin
      nxt_cur.inDrop = 1'b1;
      nxt_cur.status[ST_OUT_DROP] = 1'b1;
      nxt_cur.status[ST_FABRIC_IRQ] = 1'b1;
    end
    // multicast copy timeout
    if (mcCopyBlocked) begin
      nxt_cur.mcDrop = 1'b1;
      nxt_cur.status[ST_MC_TIMEOUT] = 1'b1;
    end
    // multicast latency timer
    if (bcastDraining || !bcastPktHeld || latExpire) begin
      nxt_cur.latRun = 1'b0;
      nxt_cur.latCnt = '0;
    end else begin
      nxt_cur.latRun = 1'b1;
      nxt_cur.latCnt = cur_ff.latCnt + LAT_W'(1);
    end
    if (latExpire) begin
      nxt_cur.purge = 1'b1;
      nxt_cur.status[ST_LAT_EXPIRED] = 1'b1;
    end
    // port-write for error flags
    if (|(errEvents & cur_ff.pwEn)) nxt_cur.pwReq = 1'b1;
    // interrupt from any enabled sticky flag; enables come from the next state
    // so a newly written enable shows on the pin with no cycle of lag
    nxt_cur.intN = !(|(nxt_cur.errFlags & nxt_cur.notifyEn) ||
      (nxt_cur.status[ST_DEGRADED] && nxt_cur.ctrl[CTL_DEG_IRQ]) ||
      (nxt_cur.status[ST_FAILED] && nxt_cur.ctrl[CTL_FAIL_IRQ]) ||
      |nxt_cur.status[NUM_ST-1:ST_OUT_DROP]);
    // apb answer one cycle into the access phase
    if (apbAccess) begin
      nxt_cur.ready = 1'b1;
      nxt_cur.slvErr = !isMapped(paddr);
      nxt_cur.rdata = '0;
      if (!pwrite) begin
        unique case (paddr)
          REG_ERR_DETECT: nxt_cur.rdata = 32'(cur_ff.errFlags);
          REG_ERR_NOTIFY_EN: nxt_cur.rdata = 32'(cur_ff.notifyEn);
          REG_ERR_PW_EN: nxt_cur.rdata = 32'(cur_ff.pwEn);
          REG_RATE_ENABLE: nxt_cur.rdata = 32'(cur_ff.rateEn);
          REG_RATE_CTRL: nxt_cur.rdata = 32'({cur_ff.headroom, cur_ff.biasPeriod});
          REG_RATE_THRESH: nxt_cur.rdata = 32'({cur_ff.failThresh, cur_ff.degThresh});
          REG_PORT_STATUS: nxt_cur.rdata = 32'(cur_ff.status);
          REG_PORT_CTRL: nxt_cur.rdata = 32'(cur_ff.ctrl);
          REG_LATENCY: nxt_cur.rdata = 32'(cur_ff.latPeriod);
          REG_RATE_COUNTER: nxt_cur.rdata = 32'({cur_ff.peak, cur_ff.rateCnt});
          default: nxt_cur.rdata = '0;
        endcase
      end
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      cur_ff <= '0;
      cur_ff.rateEn <= ENABLE_RESET;
      cur_ff.biasPeriod <= BIAS_RESET;
      cur_ff.headroom <= HEADROOM_RESET;
      cur_ff.degThresh <= DEG_RESET;
      cur_ff.failThresh <= FAIL_RESET;
      cur_ff.latPeriod <= LAT_MAX;
      cur_ff.degArmed <= 1'b1;
      cur_ff.failArmed <= 1'b1;
      cur_ff.intN <= 1'b1;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  // outputs straight from flip-flops
  assign prdata = cur_ff.rdata;
  assign pready = cur_ff.ready;
  assign pslverr = cur_ff.slvErr;
  assign intN = cur_ff.intN;
  assign portWriteReq = cur_ff.pwReq;
  assign txDrop = cur_ff.txDrop;
  assign ingressDrop = cur_ff.inDrop;
  assign mcCopyDrop = cur_ff.mcDrop;
  assign bcastPurge = cur_ff.purge;
  assign congestionCount = cur_ff.congCnt;

  // ==========================================================
  // assertions
  sequence seqOverLong;
    rxPktEnd && (rxPktBytes > 9'(MAX_PKT_BYTES));
  endsequence

  oversize_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    seqOverLong |=> cur_ff.errFlags[OVERSIZE_BIT]) else $error("oversize flag not set");
  seq_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxAckIdOutOfSeq |=> cur_ff.errFlags[BAD_SEQ_BIT]) else $error("sequence flag missing");
  crc_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxSymbolCrcBad |=> cur_ff.errFlags[CS_CRC_BIT]) else $error("crc flag missing");
  flag_sticky_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cur_ff.errFlags[PROTO_BIT] && !wrEn) |=> cur_ff.errFlags[PROTO_BIT])
    else $error("flag dropped without clear");
  rate_ceiling_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ({1'b0, cur_ff.rateCnt} >= ceiling && !wrEn) |=>
    (cur_ff.rateCnt <= $past(cur_ff.rateCnt)))
    else $error("counter passed ceiling");
  both_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (incr && decr && !wrEn) |=> $stable(cur_ff.rateCnt)) else $error("counter moved");
  peak_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !wrEn |=> cur_ff.peak >= $past(cur_ff.peak)) else $error("peak lowered by hardware");
  fail_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    txDrop |-> cur_ff.status[ST_OUT_DROP] && cur_ff.status[ST_OUT_FAIL])
    else $error("drop without flags");
  fwd_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (cur_ff.ctrl[CTL_FWD_TO_EN] && forwardTimeout) |=> ingressDrop && cur_ff.status[ST_FABRIC_IRQ])
    else $error("forward timeout not handled");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|(cur_ff.errFlags & cur_ff.notifyEn)) |-> !intN) else $error("interrupt not asserted");
  deg_once_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(cur_ff.status[ST_DEGRADED]) |-> !cur_ff.degArmed) else $error("degraded rearm");
  // remaining receive error flags, one cycle after their strobes
  resp_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxRespIdUnused |=> cur_ff.errFlags[BAD_RESP_BIT]) else $error("response id flag missing");
  proto_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxUnexpectedSymbol |=> cur_ff.errFlags[PROTO_BIT]) else $error("protocol flag missing");
  delin_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxDelineation |=> cur_ff.errFlags[DELIN_BIT]) else $error("delineation flag missing");
  accept_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxUnexpectedAccept |=> cur_ff.errFlags[UNEXP_ACC_BIT]) else $error("accept flag missing");
  timeout_flag_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    ackTimerExpired |=> cur_ff.errFlags[ACK_TO_BIT]) else $error("timeout flag missing");
  // counter moves by exactly one on a lone increment or a lone tick
  count_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (incr && !decr && !wrEn) |=> cur_ff.rateCnt == $past(cur_ff.rateCnt) + 8'h01)
    else $error("counter missed an error");
  bias_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (decr && !incr && !wrEn) |=> cur_ff.rateCnt == $past(cur_ff.rateCnt) - 8'h01)
    else $error("counter missed a tick");
  masked_err_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|(errEvents & ~cur_ff.rateEn) && !(|(errEvents & cur_ff.rateEn)) && !decr && !wrEn)
    |=> $stable(cur_ff.rateCnt)) else $error("masked error counted");
  // threshold crossing: armed and reached, then event raised and disarmed
  sequence seqDegReach;
    cur_ff.degArmed && (cur_ff.rateCnt >= cur_ff.degThresh);
  endsequence
  sequence seqFailReach;
    cur_ff.failArmed && (cur_ff.rateCnt >= cur_ff.failThresh);
  endsequence
  deg_raise_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    seqDegReach |=> cur_ff.status[ST_DEGRADED] && !cur_ff.degArmed)
    else $error("degraded event missing");
  fail_raise_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    seqFailReach |=> cur_ff.status[ST_FAILED] && !cur_ff.failArmed)
    else $error("failed event missing");
  fail_once_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(cur_ff.status[ST_FAILED]) |-> !cur_ff.failArmed) else $error("failed rearm");
  // discard pulses, latency timer hold and error port-write
  mc_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    mcCopyBlocked |=> mcCopyDrop && cur_ff.status[ST_MC_TIMEOUT])
    else $error("copy not dropped");
  lat_purge_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    latExpire |=> bcastPurge && cur_ff.status[ST_LAT_EXPIRED])
    else $error("buffer not purged");
  lat_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    bcastDraining |=> !cur_ff.latRun && (cur_ff.latCnt == '0))
    else $error("latency timer ran while draining");
  pw_notify_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    (|(errEvents & cur_ff.pwEn)) |=> portWriteReq)
    else $error("port-write missing");
endmodule : perm_monitor

/* File: verif/perm_link_model.sv */
// link partner model that raises receive and link error strobes
`timescale 1ns/1ps
module perm_link_model (
  input wire logic sys_clk,
  output logic [6:0] evStrobe,
  output logic rxPktEnd,
  output logic [8:0] rxPktBytes
);
  initial begin
    evStrobe = 7'h00;
    rxPktEnd = 1'b0;
    rxPktBytes = 9'h000;
  end
  // ==========================================================
  // one event after lag + 1 cycles; flag bit 1 ends a packet of len bytes
  task automatic fire(input int b, input logic [8:0] len, input int lag);
    repeat (lag + 1) @(posedge sys_clk);
    if (b == 1) begin
      rxPktEnd <= 1'b1;
      rxPktBytes <= len;
    end else begin
      evStrobe[(b == 0) ? 0 : b - 1] <= 1'b1;
    end
    @(posedge sys_clk);
    evStrobe <= 7'h00;
    rxPktEnd <= 1'b0;
    rxPktBytes <= ~len; // released length bus shows no stale value
  endtask : fire
endmodule : perm_link_model

/* File: verif/tb_perm_monitor.sv */
// self-checking bench for the port error event and rate monitor
`timescale 1ns/1ps
module tb_perm_monitor;
  import perm_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, se, intN, portWriteReq, txDrop, ingressDrop, mcCopyDrop, bcastPurge;
  logic [6:0] evStrobe;
  logic rxPktEnd;
  logic [8:0] rxPktBytes;
  logic txBusy = 1'b0;
  logic forwardTimeout = 1'b0;
  logic mcCopyBlocked = 1'b0;
  logic bcastPktHeld = 1'b0;
  logic bcastDraining = 1'b0;
  logic [CNT_W-1:0] congestionCount;
  int mismatches = 0;
  int n_checks = 0;
  int pwCnt = 0, txCnt = 0, inCnt = 0, mcCnt = 0, purgeCnt = 0;
  int mFlags = 0, mCnt = 0, mPeak = 0, mSt = 0, mDeg = 255, mFail = 255, mHead = 0;
  int mRateEn = 0, mDrop = 0, n, p0, t0;

  always #25 sys_clk = ~sys_clk;
  // ==========================================================
  // pulse counters on the notification and discard outputs
  always @(posedge sys_clk) begin
    pwCnt <= pwCnt + int'(portWriteReq === 1'b1);
    txCnt <= txCnt + int'(txDrop === 1'b1);
    inCnt <= inCnt + int'(ingressDrop === 1'b1);
    mcCnt <= mcCnt + int'(mcCopyDrop === 1'b1);
    purgeCnt <= purgeCnt + int'(bcastPurge === 1'b1);
  end

  perm_link_model link_inst (.sys_clk(sys_clk), .evStrobe(evStrobe), .rxPktEnd(rxPktEnd),
    .rxPktBytes(rxPktBytes));

  perm_monitor perm_monitor_inst (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxAckIdOutOfSeq(evStrobe[0]), .rxPktEnd(rxPktEnd),
    .rxPktBytes(rxPktBytes), .rxRespIdUnused(evStrobe[1]), .rxUnexpectedSymbol(evStrobe[2]),
    .rxDelineation(evStrobe[3]), .rxUnexpectedAccept(evStrobe[4]),
    .ackTimerExpired(evStrobe[5]), .rxSymbolCrcBad(evStrobe[6]), .txBusy(txBusy),
    .forwardTimeout(forwardTimeout), .mcCopyBlocked(mcCopyBlocked),
    .bcastPktHeld(bcastPktHeld), .bcastDraining(bcastDraining), .intN(intN),
    .portWriteReq(portWriteReq), .txDrop(txDrop), .ingressDrop(ingressDrop),
    .mcCopyDrop(mcCopyDrop), .bcastPurge(bcastPurge), .congestionCount(congestionCount));

  // ==========================================================
  // comparison, verdict and apb master
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %08h expected %08h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) begin
      mismatches++;
      close_out();
    end
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  // one error from the link partner, mirrored in the reference model
  task automatic err(input int b, input logic [8:0] len);
    link_inst.fire(b, len, $urandom_range(0, 2));
    if (b != 1 || len > 9'd276) begin
      mFlags |= 1 << b;
      if (mRateEn[b]) begin
        if (mCnt < mFail + mHead) mCnt++;
        if (mCnt > mPeak) mPeak = mCnt;
        if (mCnt >= mDeg) mSt |= 1;
        if (mCnt >= mFail) mSt |= 2 | mDrop;
      end
    end
    repeat (2) @(posedge sys_clk);
  endtask : err

  // ==========================================================
  // main sequence
  initial begin
    n = $urandom(59766);
    repeat (12) @(posedge sys_clk);
    nrst <= 1'b1;
    rdchk(REG_RATE_THRESH, 32'h0000FFFF);
    rdchk(REG_LATENCY, {8'h00, LAT_MAX});
    rdchk(8'h28, 32'h0);
    chk(se, 1'b1);
    apb(1'b1, REG_ERR_NOTIFY_EN, 32'hFF);
    err(1, 9'd276);
    rdchk(REG_ERR_DETECT, 32'h0);
    for (int b = 0; b < NUM_ERR; b++) begin
      err(b, 9'd277);
      chk(intN, 1'b0);
      rdchk(REG_ERR_DETECT, mFlags);
      apb(1'b1, REG_ERR_DETECT, mFlags);
      mFlags = 0;
      repeat (2) @(posedge sys_clk);
      chk(intN, 1'b1);
    end
    // counter climbs to its ceiling, degraded port-write raised once
    mDeg = 2;
    mFail = 3;
    mHead = 1;
    mRateEn = 255;
    apb(1'b1, REG_RATE_ENABLE, 32'hFF);
    apb(1'b1, REG_RATE_THRESH, 32'h0302);
    apb(1'b1, REG_RATE_CTRL, 32'h00010000);
    apb(1'b1, REG_PORT_CTRL, 32'h10);
    p0 = pwCnt;
    n = $urandom_range(5, 8);
    for (int i = 0; i < n; i++) err($urandom_range(0, 7), 9'd277);
    rdchk(REG_RATE_COUNTER, (mPeak << 8) | mCnt);
    rdchk(REG_PORT_STATUS, mSt);
    chk(pwCnt - p0, 1);
    // bias ticks drain the counter to zero, peak kept
    apb(1'b1, REG_RATE_CTRL, 32'h00010003);
    repeat (60) @(posedge sys_clk);
    mCnt = 0;
    rdchk(REG_RATE_COUNTER, mPeak << 8);
    chk({24'h0, congestionCount}, 32'h0);
    // errors while ticks run make increment and tick meet in one cycle
    for (int i = 0; i < 8; i++) err(0, 9'd0);
    // masked error ignored, then failed threshold drops the outgoing packet
    apb(1'b1, REG_RATE_CTRL, 32'h00010000);
    apb(1'b1, REG_RATE_COUNTER, 32'h0);
    apb(1'b1, REG_PORT_STATUS, 32'h7F);
    apb(1'b1, REG_RATE_ENABLE, 32'h01);
    apb(1'b1, REG_PORT_CTRL, 32'h01);
    mCnt = 0;
    mPeak = 0;
    mSt = 0;
    mRateEn = 1;
    mDrop = 12;
    txBusy <= 1'b1;
    t0 = txCnt;
    err(3, 9'd0);
    for (int i = 0; i < 3; i++) err(0, 9'd0);
    rdchk(REG_RATE_COUNTER, (mPeak << 8) | mCnt);
    rdchk(REG_PORT_STATUS, mSt);
    chk(txCnt > t0, 1'b1);
    // forward timeout, multicast copy timeout and latency expiry
    apb(1'b1, REG_PORT_CTRL, 32'h02);
    apb(1'b1, REG_LATENCY, 32'h8);
    txBusy <= 1'b0;
    forwardTimeout <= 1'b1;
    @(posedge sys_clk);
    forwardTimeout <= 1'b0;
    mcCopyBlocked <= 1'b1;
    @(posedge sys_clk);
    mcCopyBlocked <= 1'b0;
    bcastPktHeld <= 1'b1;
    repeat (30) @(posedge sys_clk);
    bcastPktHeld <= 1'b0;
    mSt |= 4 | 16 | 32 | 64;
    rdchk(REG_PORT_STATUS, mSt);
    chk({inCnt > 0, mcCnt > 0, purgeCnt > 0}, 3'b111);
    // error flag port-write, then no purge while the buffer drains
    apb(1'b1, REG_ERR_PW_EN, 32'h80);
    p0 = pwCnt;
    err(7, 9'd0);
    chk(pwCnt - p0, 1);
    t0 = purgeCnt;
    bcastDraining <= 1'b1;
    bcastPktHeld <= 1'b1;
    repeat (30) @(posedge sys_clk);
    chk(purgeCnt - t0, 0);
    bcastPktHeld <= 1'b0;
    bcastDraining <= 1'b0;
    close_out();
  end
endmodule : tb_perm_monitor
